// ===== torque_adapt.v
// load-adaptive coil current control with no-load loss learning, wishbone register slave
`include "torque_adapt_consts.vh"

// Function
// - adaptation only while enable bit set
// - first level is base times eight
// - second level adds decoded increment
// - store low and high learned losses
// - interpolate loss between learned points
// - lower current on light load, raise fast
// - increment code decodes 128,16,32,64
// - hold level 8/16/24/32 half cycles
// - trigger runs first then second level
// - finish clears trigger, sets complete
module torque_adapt (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire half_cycle_i,
    input wire [10:0] supply_power_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg [7:0] current_o,
    output reg learning_o,
    output reg irq_o
);
    localparam [1:0] st_idle = 2'b00;
    localparam [1:0] st_low = 2'b01;
    localparam [1:0] st_high = 2'b10;

    reg torque_adapt_enable;
    reg learn_trigger;
    reg learn_complete;
    reg [4:0] learn_base_current;
    reg [1:0] learn_current_increment;
    reg [1:0] learn_halfcycle_select;
    reg [10:0] learned_loss_low;
    reg [10:0] learned_loss_high;
    reg [7:0] limit_min;
    reg [7:0] limit_max;
    reg [7:0] band_low;
    reg [7:0] band_high;
    reg [7:0] fixed_current;
    reg [`TA_IRQ_WIDTH-1:0] irq_status;
    reg [`TA_IRQ_WIDTH-1:0] irq_mask;
    reg [1:0] state;
    reg [5:0] halfcycles;
    reg [17:0] power_acc;
    reg [10:0] load_power_count;
    reg count_over;
    reg count_under;

    reg [8:0] increment;
    wire [8:0] level_low;
    wire [8:0] level_high;
    wire [10:0] loss_estimate;
    wire [5:0] halfcycle_target;
    wire [10:0] measured;
    wire [3:0] reg_index;
    wire bus_req;
    wire bus_write;
    wire [31:0] wmask;
    reg [31:0] next_dat;
    reg [`TA_IRQ_WIDTH-1:0] irq_events;
    reg [7:0] next_current;
    wire [24:0] third_prod;
    wire over_band;
    wire under_band;
    wire sample_pulse;

    assign reg_index = adr_i[5:2];
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_write = bus_req & we_i;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    always @* begin
        case (learn_current_increment)
            2'b00: increment = `TA_INC_00;
            2'b01: increment = `TA_INC_01;
            2'b10: increment = `TA_INC_10;
            default: increment = `TA_INC_11;
        endcase
    end

    assign level_low = {1'b0, learn_base_current, 3'b000};
    assign level_high = level_low + increment;
    assign halfcycle_target = ({4'h0, learn_halfcycle_select} + 6'h01) * `TA_HALFCYCLE_UNIT;

    loss_interp u_interp (
        .level_low_i(level_low),
        .level_high_i(level_high),
        .loss_low_i(learned_loss_low),
        .loss_high_i(learned_loss_high),
        .current_i(current_o),
        .loss_estimate_o(loss_estimate)
    );

    // mean supply power over the half cycles of one level; 24 is no power of two, so that case
    // takes an eighth and multiplies by 683/2048, which is exact for a steady sample
    assign third_prod = power_acc[17:3] * 10'h2ab;
    assign measured = (learn_halfcycle_select == 2'b00) ? power_acc[13:3] :
                      (learn_halfcycle_select == 2'b01) ? power_acc[14:4] :
                      (learn_halfcycle_select == 2'b11) ? power_acc[15:5] :
                      third_prod[21:11];

    always @* begin
        case (reg_index)
            `TA_ADDR_CTRL: next_dat = {30'h0, learn_trigger, torque_adapt_enable};
            `TA_ADDR_LEARN: next_dat = {23'h0, learn_halfcycle_select, learn_current_increment,
                                        learn_base_current};
            `TA_ADDR_CONST_LOW: next_dat = {21'h0, learned_loss_low};
            `TA_ADDR_CONST_HIGH: next_dat = {21'h0, learned_loss_high};
            `TA_ADDR_LIMITS: next_dat = {8'h0, fixed_current, limit_max, limit_min};
            `TA_ADDR_BAND: next_dat = {16'h0, band_high, band_low};
            `TA_ADDR_STATUS: next_dat = {5'h00, count_under, count_over, learn_complete, loss_estimate,
                                         load_power_count, state};
            `TA_ADDR_IRQ_STATUS: next_dat = {29'h0, irq_status};
            `TA_ADDR_IRQ_MASK: next_dat = {29'h0, irq_mask};
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always @* begin
        next_current = current_o;
        if (state == st_low) begin
            next_current = level_low[7:0];
        end else if (state == st_high) begin
            next_current = level_high[8] ? 8'hff : level_high[7:0];
        end else if (!torque_adapt_enable) begin
            next_current = fixed_current;
        end else if (count_over) begin
            // jump straight to the ceiling: a slow ramp under rising load is what loses steps
            next_current = limit_max;
        end else if (count_under && half_cycle_i && current_o > limit_min) begin
            next_current = current_o - 8'h01;
        end else if (current_o < limit_min) begin
            next_current = limit_min;
        end else if (current_o > limit_max) begin
            next_current = limit_max;
        end
    end

    assign over_band = ({3'b000, band_high} < load_power_count) && torque_adapt_enable;
    assign under_band = ({3'b000, band_low} > load_power_count) && torque_adapt_enable;
    // count a half cycle only once the coil holds the level: a pulse while the old current
    // still flows would spoil the learned mean
    assign sample_pulse = half_cycle_i && learning_o && (current_o == next_current);

    // band crossings count on their rising edge only; done fires as the high level ends
    always @* begin
        irq_events = {`TA_IRQ_WIDTH{1'b0}};
        irq_events[`TA_IRQ_OVER_BIT] = over_band && !count_over;
        irq_events[`TA_IRQ_UNDER_BIT] = under_band && !count_under;
        irq_events[`TA_IRQ_DONE_BIT] = (state == st_high) && (halfcycles >= halfcycle_target);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            torque_adapt_enable <= 1'b0;
            learn_trigger <= 1'b0;
            learn_complete <= 1'b0;
            learn_base_current <= 5'h00;
            learn_current_increment <= 2'b00;
            learn_halfcycle_select <= 2'b00;
            learned_loss_low <= 11'h000;
            learned_loss_high <= 11'h000;
            limit_min <= `TA_RESET_LIMIT_MIN;
            limit_max <= `TA_RESET_LIMIT_MAX;
            band_low <= `TA_RESET_BAND_LOW;
            band_high <= `TA_RESET_BAND_HIGH;
            fixed_current <= `TA_RESET_FIXED;
            irq_status <= {`TA_IRQ_WIDTH{1'b0}};
            irq_mask <= {`TA_IRQ_WIDTH{1'b0}};
            irq_o <= 1'b0;
            state <= st_idle;
            halfcycles <= 6'h00;
            power_acc <= 18'h0_0000;
            load_power_count <= 11'h000;
            count_over <= 1'b0;
            count_under <= 1'b0;
            current_o <= `TA_RESET_FIXED;
            learning_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
            if (bus_req && !we_i) begin
                dat_o <= next_dat;
            end
            if (bus_write) begin
                case (reg_index)
                    `TA_ADDR_CTRL: begin
                        if (sel_i[0]) begin
                            torque_adapt_enable <= dat_i[`TA_CTRL_ENABLE_BIT];
                        end
                    end
                    `TA_ADDR_LEARN: begin
                        if (sel_i[0]) begin
                            learn_base_current <= dat_i[4:0];
                            learn_current_increment <= dat_i[6:5];
                            learn_halfcycle_select[0] <= dat_i[7];
                        end
                        if (sel_i[1]) begin
                            learn_halfcycle_select[1] <= dat_i[8];
                        end
                    end
                    `TA_ADDR_CONST_LOW: begin
                        learned_loss_low <= (learned_loss_low & ~wmask[10:0]) | (dat_i[10:0] & wmask[10:0]);
                    end
                    `TA_ADDR_CONST_HIGH: begin
                        learned_loss_high <= (learned_loss_high & ~wmask[10:0]) | (dat_i[10:0] & wmask[10:0]);
                    end
                    `TA_ADDR_LIMITS: begin
                        if (sel_i[0]) limit_min <= dat_i[7:0];
                        if (sel_i[1]) limit_max <= dat_i[15:8];
                        if (sel_i[2]) fixed_current <= dat_i[23:16];
                    end
                    `TA_ADDR_BAND: begin
                        if (sel_i[0]) band_low <= dat_i[7:0];
                        if (sel_i[1]) band_high <= dat_i[15:8];
                    end
                    `TA_ADDR_IRQ_MASK: begin
                        if (sel_i[0]) irq_mask <= dat_i[`TA_IRQ_WIDTH-1:0];
                    end
                    default: begin
                    end
                endcase
            end

            // load share of power: supply power above the interpolated no-load loss
            load_power_count <= (supply_power_i > loss_estimate) ? supply_power_i - loss_estimate : 11'h000;
            count_over <= over_band;
            count_under <= under_band;

            case (state)
                st_idle: begin
                    if (bus_write && reg_index == `TA_ADDR_CTRL && sel_i[0] && dat_i[`TA_CTRL_TRIGGER_BIT]) begin
                        learn_trigger <= 1'b1;
                        learn_complete <= 1'b0;
                        state <= st_low;
                        halfcycles <= 6'h00;
                        power_acc <= 18'h0_0000;
                    end
                end
                st_low: begin
                    // greater-or-equal so a selection narrowed mid-run cannot hang the level
                    if (halfcycles >= halfcycle_target) begin
                        learned_loss_low <= measured;
                        state <= st_high;
                        halfcycles <= 6'h00;
                        power_acc <= 18'h0_0000;
                    end else if (sample_pulse) begin
                        power_acc <= power_acc + {7'h00, supply_power_i};
                        halfcycles <= halfcycles + 6'h01;
                    end
                end
                st_high: begin
                    if (halfcycles >= halfcycle_target) begin
                        learned_loss_high <= measured;
                        learn_trigger <= 1'b0;
                        learn_complete <= 1'b1;
                        state <= st_idle;
                    end else if (sample_pulse) begin
                        power_acc <= power_acc + {7'h00, supply_power_i};
                        halfcycles <= halfcycles + 6'h01;
                    end
                end
                default: state <= st_idle;
            endcase

            current_o <= (state != st_idle) ? next_current :
                         ((count_over && torque_adapt_enable) ? limit_max : next_current);
            learning_o <= (state != st_idle);
            // set wins over write-one-to-clear
            if (bus_write && reg_index == `TA_ADDR_IRQ_STATUS && sel_i[0]) begin
                irq_status <= (irq_status & ~dat_i[`TA_IRQ_WIDTH-1:0]) | irq_events;
                irq_o <= |(((irq_status & ~dat_i[`TA_IRQ_WIDTH-1:0]) | irq_events) & irq_mask);
            end else begin
                irq_status <= irq_status | irq_events;
                irq_o <= |((irq_status | irq_events) & irq_mask);
            end
        end
    end
endmodule // torque_adapt

// ===== torque_adapt_consts.vh
// register map, field positions, reset values and constants of the load-adaptive current block
`ifndef TORQUE_ADAPT_CONSTS_VH
`define TORQUE_ADAPT_CONSTS_VH

`define TA_ADDR_CTRL 4'h0
`define TA_ADDR_LEARN 4'h1
`define TA_ADDR_CONST_LOW 4'h2
`define TA_ADDR_CONST_HIGH 4'h3
`define TA_ADDR_LIMITS 4'h4
`define TA_ADDR_BAND 4'h5
`define TA_ADDR_STATUS 4'h6
`define TA_ADDR_IRQ_STATUS 4'h7
`define TA_ADDR_IRQ_MASK 4'h8

`define TA_CTRL_ENABLE_BIT 0
`define TA_CTRL_TRIGGER_BIT 1

`define TA_IRQ_DONE_BIT 0
`define TA_IRQ_OVER_BIT 1
`define TA_IRQ_UNDER_BIT 2
`define TA_IRQ_WIDTH 3

`define TA_BASE_SHIFT 3
`define TA_INC_00 9'h080
`define TA_INC_01 9'h010
`define TA_INC_10 9'h020
`define TA_INC_11 9'h040
`define TA_HALFCYCLE_UNIT 6'h08

`define TA_RESET_LIMIT_MIN 8'h20
`define TA_RESET_LIMIT_MAX 8'hff
`define TA_RESET_BAND_LOW 8'h10
`define TA_RESET_BAND_HIGH 8'h40
`define TA_RESET_FIXED 8'h80

`endif

// ===== loss_interp.v
// linear interpolation of the loss estimate between two learned points
module loss_interp (
    input wire [8:0] level_low_i,
    input wire [8:0] level_high_i,
    input wire [10:0] loss_low_i,
    input wire [10:0] loss_high_i,
    input wire [7:0] current_i,
    output wire [10:0] loss_estimate_o
);
    wire signed [12:0] dy;
    wire signed [10:0] dx;
    wire signed [10:0] di;
    wire signed [24:0] prod;
    wire signed [24:0] quot;
    wire signed [25:0] sum;

    assign dy = $signed({2'b00, loss_high_i}) - $signed({2'b00, loss_low_i});
    assign dx = $signed({2'b00, level_high_i}) - $signed({2'b00, level_low_i});
    assign di = $signed({3'b000, current_i}) - $signed({2'b00, level_low_i});
    assign prod = dy * di;
    // zero step degenerates to the low constant rather than dividing by zero
    assign quot = (dx == 11'sd0) ? 25'sd0 : prod / dx;
    assign sum = $signed({15'h0000, loss_low_i}) + {quot[24], quot};
    assign loss_estimate_o = sum[25] ? 11'h000 : (|sum[24:11] ? 11'h7ff : sum[10:0]);
endmodule // loss_interp

// ===== motor_model.sv
// winding model: half-cycle pulses and the supply power drawn
module motor_model #(parameter int HALF_PERIOD = 20) (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] current_i,
    input wire [10:0] load_i,
    output logic half_cycle_o,
    output wire [10:0] power_o
);
    timeunit 1ns;
    timeprecision 1ps;
    integer cnt;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            half_cycle_o <= 1'b0;
        end else begin
            cnt <= (cnt == HALF_PERIOD - 1) ? 0 : cnt + 1;
            half_cycle_o <= (cnt == HALF_PERIOD - 1);
        end
    end
    // loss linear in coil current, so two learned points predict it exactly
    assign power_o = {2'b00, current_i, 1'b0} + load_i;
endmodule // motor_model

// ===== torque_adapt_sva.sv
// port-level assertions for the load-adaptive current block
module torque_adapt_sva (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire half_cycle_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire [7:0] current_o,
    input wire learning_o,
    input wire irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_dat_on_ack: assert property ($changed(dat_o) |-> ack_o) else $error("read data moved without ack");
    a_reset_state: assert property ($fell(rst_i) |->
        current_o == 8'h80 && !ack_o && !learning_o && !irq_o) else $error("bad state after reset");
    a_level_base: assert property ($rose(learning_o) |-> ##[0:2] current_o[2:0] == 3'h0)
        else $error("first level not a multiple of eight");
    a_level_rises: assert property (learning_o && $past(learning_o) && $past(learning_o, 2)
        && $past(learning_o, 3) |-> current_o >= $past(current_o)) else $error("learning level fell");
    a_switch_on_half: assert property (learning_o && $past(learning_o, 3) && $changed(current_o)
        |-> $past(half_cycle_i, 3)) else $error("level change off a half cycle");
    a_step_down_one: assert property (!learning_o && !$past(cyc_i) && !$past(cyc_i, 2)
        && current_o < $past(current_o) |-> current_o == $past(current_o) - 8'h01) else $error("step not one");
    a_step_on_half: assert property (!learning_o && !$past(cyc_i) && !$past(cyc_i, 2)
        && current_o < $past(current_o) |-> $past(half_cycle_i) || $past(half_cycle_i, 2))
        else $error("step down off a half cycle");
endmodule // torque_adapt_sva
bind torque_adapt torque_adapt_sva i_torque_adapt_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .half_cycle_i, .dat_o,
    .ack_o, .current_o, .learning_o, .irq_o);

// ===== load_adaptive_current_learning_bench.sv
// self-checking bench for the load-adaptive current block
`include "torque_adapt_consts.vh"
module load_adaptive_current_learning_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [5:0] adr_i = 6'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [10:0] load = 11'h000;
    wire half_cycle_i, ack_o, learning_o, irq_o;
    wire [10:0] supply_power_i;
    wire [31:0] dat_o;
    wire [7:0] current_o;
    logic [31:0] exp_q[$], msk_q[$];
    integer bad_count = 0, tests_run = 0, seed = 95282, n1, n2, k, base, lvl1, lvl2, num;
    torque_adapt i_torque_adapt (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .half_cycle_i,
        .supply_power_i, .dat_o, .ack_o, .current_o, .learning_o, .irq_o);
    motor_model i_motor_model (.clk_i, .rst_i, .current_i(current_o), .load_i(load), .half_cycle_o(half_cycle_i),
        .power_o(supply_power_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task chk(input string name, input [31:0] e, input [31:0] s);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask
    // reads carry the expected word in d, compared under mask m by the monitor
    task bus(input w, input [3:0] idx, input [31:0] d, input [31:0] m);
        integer n;
        n = 0;
        @(posedge clk_i);
        if (!w) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
        if (n >= 20) chk("bus ack", 1, 0);
    endtask
    task wait_learn(input v, input integer lim);
        integer n;
        n = 0;
        while (learning_o !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk("learning flag", v, learning_o);
    endtask
    task wait_cur(input [7:0] v, input integer lim);
        integer n;
        n = 0;
        while (current_o !== v && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk("current", v, current_o);
    endtask
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) chk("read data", exp_q.pop_front(),
            dat_o & msk_q.pop_front());
        if (learning_o === 1'b1 && half_cycle_i === 1'b1) begin
            if (current_o === lvl1[7:0]) n1++;
            else if (current_o === lvl2[7:0]) n2++;
        end
    end
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `TA_ADDR_CTRL, 0, 32'h0000_0003);
        bus(0, `TA_ADDR_LIMITS, 32'h0080_ff20, 32'h00ff_ffff);
        bus(0, `TA_ADDR_BAND, 32'h0000_4010, 32'h0000_ffff);
        bus(1, 4'hf, 32'hffff_ffff, 0);
        bus(0, 4'hf, 0, 32'hffff_ffff);
        bus(1, `TA_ADDR_LIMITS, 32'h005a_ff20, 0);
        wait_cur(8'h5a, 10);
        bus(1, `TA_ADDR_IRQ_MASK, 1, 0);
        for (k = 0; k < 4; k++) begin
            base = 4 + ($random(seed) & 7);
            lvl1 = base * 8;
            lvl2 = lvl1 + (k == 0 ? 128 : 8 << k);
            num = 8 * (k + 1);
            n1 = 0;
            n2 = 0;
            if (k == 3) bus(1, `TA_ADDR_IRQ_MASK, 0, 0);
            bus(1, `TA_ADDR_LEARN, k << 7 | k << 5 | base, 0);
            bus(1, `TA_ADDR_CTRL, 1, 0);
            bus(1, `TA_ADDR_CTRL, 3, 0);
            wait_learn(1, 40);
            wait_learn(0, 3000);
            repeat (3) @(posedge clk_i);
            chk("low level half cycles", num, n1);
            chk("high level half cycles", num, n2);
            chk("irq", k != 3, irq_o);
            bus(0, `TA_ADDR_CTRL, 1, 32'h0000_0003);
            bus(0, `TA_ADDR_STATUS, 32'h0100_0000, 32'h0100_0000);
            bus(0, `TA_ADDR_IRQ_STATUS, 1, 1);
            bus(0, `TA_ADDR_CONST_LOW, 2 * lvl1, 32'h0000_07ff);
            bus(0, `TA_ADDR_CONST_HIGH, 2 * lvl2, 32'h0000_07ff);
            bus(1, `TA_ADDR_IRQ_STATUS, 1, 0);
            repeat (3) @(posedge clk_i);
            chk("irq cleared", 0, irq_o);
        end
        bus(1, `TA_ADDR_LIMITS, 32'h005a_0000 | lvl2 << 8 | lvl1, 0);
        wait_cur(lvl1, 3000);
        load <= 11'h0c8;
        wait_cur(lvl2, 50);
        bus(0, `TA_ADDR_IRQ_STATUS, 6, 6);
        bus(1, `TA_ADDR_IRQ_MASK, 2, 0);
        repeat (3) @(posedge clk_i);
        chk("irq over", 1, irq_o);
        bus(1, `TA_ADDR_IRQ_STATUS, 7, 0);
        load <= 11'h000;
        bus(1, `TA_ADDR_CTRL, 0, 0);
        bus(1, `TA_ADDR_LEARN, 8, 0);
        bus(1, `TA_ADDR_CONST_LOW, 100, 0);
        bus(1, `TA_ADDR_CONST_HIGH, 300, 0);
        bus(1, `TA_ADDR_LIMITS, 32'h0080_ff20, 0);
        wait_cur(8'h80, 20);
        bus(0, `TA_ADDR_CONST_LOW, 100, 32'h0000_07ff);
        bus(0, `TA_ADDR_STATUS, 200 << 13, 32'h00ff_e000);
        end_of_test;
    end
endmodule // load_adaptive_current_learning_bench
